// ---- dv/nvmux_host.sv ----
// Serial bus master model, 64 ns bit period
module nvmux_host (
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Quarter bit; the target needs 8 mclk per scl phase
  task q;
    #16;
  endtask
  task start;
    sda_oe = 1'b0;
    // Half a bit before scl rises: the target lets go of its ack late
    q;
    q;
    scl = 1'b1;
    q;
    sda_oe = 1'b1;
    q;
    scl = 1'b0;
  endtask
  task stop;
    q;
    sda_oe = 1'b1;
    q;
    scl = 1'b1;
    q;
    sda_oe = 1'b0;
    q;
  endtask
  // Eight bits MSB first, then lb as ninth; ak is the target's ack
  task xb(input [7:0] d, input lb, output [7:0] v, output ak);
    logic [8:0] t;
    logic [8:0] s;
    int i;
    t = {d, lb};
    for (i = 8; i >= 0; i--) begin
      q;
      sda_oe = !t[i];
      q;
      scl = 1'b1;
      q;
      s[i] = sda;
      q;
      scl = 1'b0;
    end
    v = s[8:1];
    ak = !s[0];
  endtask
endmodule

// ---- dv/nvmux_sva.sv ----
// Port checker for the output selector
module nvmux_sva #(
  parameter PROG_CYCLES = 400
) (
  input wire mclk,
  input wire resetn,
  input wire scl,
  input wire wp,
  input wire force_low_n,
  input wire [4:0] external_sel_in,
  input wire [4:0] selected_out,
  input wire [4:0] selected_out_oe,
  input wire fixed_out,
  input wire fixed_out_oe,
  input wire sda_out,
  input wire sda_oe,
  input wire prog_busy
);
  int cnt;
  // ****
  // Busy length
  // ****
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
    end else begin
      cnt <= prog_busy ? cnt + 1 : 0;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_sda_pull_only: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("sda driven high");
  a_oe_pair: assert property (selected_out_oe == ~selected_out && fixed_out_oe == ~fixed_out)
    else $error("output enable not inverse of level");
  a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl && !$past(scl, 3))
    else $error("sda moved outside scl low");
  a_busy_length: assert property ($fell(prog_busy) |-> cnt == PROG_CYCLES)
    else $error("programming cycle length wrong");
  a_busy_quiet: assert property (prog_busy |-> !sda_oe)
    else $error("bus answered while programming");
  a_prog_at_stop: assert property ($rose(prog_busy) |-> scl && $past(scl, 8))
    else $error("programming began outside stop");
  a_wp_blocks: assert property ($rose(prog_busy) |-> !$past(wp, 8))
    else $error("programming while protected");
  a_force_low_mux: assert property (!force_low_n && !$past(force_low_n, 8)
    && external_sel_in == $past(external_sel_in, 8)
    |-> selected_out == 5'h00 || selected_out == external_sel_in)
    else $error("force low output wrong");
  c_prog: cover property ($rose(prog_busy));
  c_ack: cover property ($rose(sda_oe));
  c_fixed_drop: cover property ($fell(fixed_out));
endmodule

bind nvmux_top nvmux_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (.mclk, .resetn, .scl, .wp,
  .force_low_n, .external_sel_in, .selected_out, .selected_out_oe, .fixed_out, .fixed_out_oe,
  .sda_out, .sda_oe, .prog_busy);

// ---- dv/nvmux_tb.sv ----
// Testbench for the output selector
`include "nvmux_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, resetn, addr_select_pin, wp, mux_select_pin, force_low_n, ak;
  logic [4:0] external_sel_in;
  logic [7:0] r, v;
  int err_count, checked;
  wire scl, m_oe, sda_out, sda_oe, fixed_out, fixed_out_oe, prog_busy;
  wire [4:0] selected_out, selected_out_oe;
  // Pull-up wire: low when either side pulls
  wire sda = !(m_oe || sda_oe);
  wire [7:0] so = {3'h0, selected_out};
  nvmux_host h (.scl(scl), .sda_oe(m_oe), .sda(sda));
  nvmux_top #(.PROG_CYCLES(400)) dut (.mclk, .resetn, .scl, .sda_in(sda), .sda_out, .sda_oe,
    .addr_select_pin, .wp, .mux_select_pin, .force_low_n, .external_sel_in, .selected_out,
    .selected_out_oe, .fixed_out, .fixed_out_oe, .prog_busy);
  // ****
  // Helpers
  // ****
  task w(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task ck(input string s, input [7:0] seen, input [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task hdr(input [7:0] c, input a);
    h.start();
    h.xb({`NVMUX_ADDR_FIXED, a, 1'b0}, 1'b1, r, ak);
    if (ak) begin
      h.xb(c, 1'b1, r, ak);
    end
  endtask
  task rd(input [7:0] c, output [7:0] d);
    hdr(c, 1'b1);
    h.start();
    h.xb({`NVMUX_ADDR_FIXED, 1'b1, 1'b1}, 1'b1, r, ak);
    h.xb(8'hFF, 1'b1, d, ak);
    h.stop();
  endtask
  task prog(input [5:0] x);
    hdr(`NVMUX_CMD_STORE, 1'b1);
    h.xb(8'h00, 1'b1, r, ak);
    h.xb({2'h0, x}, 1'b1, r, ak);
    h.stop();
    w(4);
  endtask
  task idle;
    int i;
    for (i = 0; i < 600 && prog_busy !== 1'b0; i++) begin
      w(1);
    end
    ck("busy end", {7'h0, prog_busy}, 8'h00);
    w(8);
  endtask
  task ctl(input [7:0] d);
    hdr(`NVMUX_CMD_CTRL, 1'b1);
    h.xb(d, 1'b1, r, ak);
    h.stop();
    w(8);
  endtask
  task pins(input s, input f, input [4:0] e);
    mux_select_pin = s;
    force_low_n = f;
    external_sel_in = e;
    w(8);
  endtask
  // ****
  // Scenarios
  // ****
  task t_store;
    prog(6'h2B);
    ck("busy", {7'h0, prog_busy}, 8'h01);
    ck("hold", so, 8'h00);
    hdr(`NVMUX_CMD_STORE, 1'b1);
    h.stop();
    ck("busy nack", {7'h0, ak}, 8'h00);
    idle;
    ck("store out", so, 8'h0B);
    ck("store fixed", {7'h0, fixed_out}, 8'h01);
    rd(`NVMUX_CMD_STORE, v);
    ck("store read", v, 8'h2B);
    hdr(`NVMUX_CMD_STORE, 1'b0);
    h.stop();
    ck("other addr", {7'h0, ak}, 8'h00);
    $display("t_store done");
  endtask
  task t_wp;
    wp = 1'b1;
    w(8);
    prog(6'h15);
    ck("wp nack", {7'h0, ak}, 8'h00);
    ck("wp busy", {7'h0, prog_busy}, 8'h00);
    wp = 1'b0;
    idle;
    rd(`NVMUX_CMD_STORE, v);
    ck("wp keep", v, 8'h2B);
    $display("t_wp done");
  endtask
  task t_pin;
    pins(1'b1, 1'b1, 5'h1A);
    ck("pin in", so, 8'h1A);
    pins(1'b1, 1'b0, 5'h1A);
    ck("low in", so, 8'h1A);
    pins(1'b0, 1'b0, 5'h1A);
    ck("low st", so, 8'h00);
    ck("low fix", {7'h0, fixed_out}, 8'h00);
    pins(1'b0, 1'b1, 5'h1A);
    pins(1'b1, 1'b1, 5'h1A);
    prog(6'h0C);
    idle;
    ck("latch held", {7'h0, fixed_out}, 8'h01);
    ck("in kept", so, 8'h1A);
    pins(1'b0, 1'b1, 5'h1A);
    ck("transp", {7'h0, fixed_out}, 8'h00);
    ck("new st", so, 8'h0C);
    $display("t_pin done");
  endtask
  task t_in;
    external_sel_in = 5'h13;
    rd(`NVMUX_CMD_INPUTS, v);
    ck("inputs", v, 8'h13);
    $display("t_in done");
  endtask
  task t_reg;
    ctl(8'h01);
    ck("reg in", so, 8'h13);
    prog(6'h2B);
    idle;
    ck("reg held", {7'h0, fixed_out}, 8'h00);
    ctl(8'h03);
    ck("reg fix", {7'h0, fixed_out}, 8'h01);
    pins(1'b1, 1'b1, 5'h13);
    ck("reg st", so, 8'h0B);
    rd(`NVMUX_CMD_CTRL, v);
    ck("ctrl read", v, 8'h03);
    ctl(8'h01);
    ck("reg latch", {7'h0, fixed_out}, 8'h01);
    $display("t_reg done");
  endtask
  task finish_test;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #300000;
    err_count++;
    finish_test;
  end
  initial begin
    resetn = 1'b0;
    addr_select_pin = 1'b1;
    wp = 1'b0;
    mux_select_pin = 1'b0;
    force_low_n = 1'b1;
    external_sel_in = 5'h00;
    err_count = 0;
    checked = 0;
    w(2);
    resetn = 1'b1;
    w(8);
    t_store;
    t_wp;
    t_pin;
    t_in;
    t_reg;
    finish_test;
  end
endmodule

// ---- logic/nvmux_store.v ----
// Six-bit non-volatile store model with its programming cycle timer
`include "nvmux_map.vh"

module nvmux_store #(
  parameter PROG_CYCLES = `NVMUX_PROG_CYCLES
) (
  input wire mclk,
  input wire resetn,
  input wire prog_start,
  input wire [5:0] prog_data,
  output reg [5:0] stored,
  output reg busy
);

  reg [5:0] pending;
  reg [31:0] count;

  // ****************************************************************
  // Programming cycle
  // ****************************************************************
  // The visible value stays put until the cycle ends, so outputs never
  // show a half-written word.
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stored <= `NVMUX_STORE_RESET;
      pending <= 6'h00;
      busy <= 1'b0;
      count <= 32'h0;
    end else if (busy) begin
      if (count >= PROG_CYCLES - 1) begin
        busy <= 1'b0;
        stored <= pending;
        count <= 32'h0;
      end else begin
        count <= count + 32'h1;
      end
    end else if (prog_start) begin
      busy <= 1'b1;
      pending <= prog_data;
      count <= 32'h0;
    end
  end

endmodule

// ---- logic/nvmux_top.v ----
// Output selector with stored value, latch and serial target port
`include "nvmux_map.vh"

module nvmux_top #(
  parameter PROG_CYCLES = `NVMUX_PROG_CYCLES
) (
  input wire mclk,
  input wire resetn,
  input wire scl,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire addr_select_pin,
  input wire wp,
  input wire mux_select_pin,
  input wire force_low_n,
  input wire [4:0] external_sel_in,
  output reg [4:0] selected_out,
  output reg [4:0] selected_out_oe,
  output reg fixed_out,
  output reg fixed_out_oe,
  output reg prog_busy
);

  localparam S_IDLE = 5'b00001;
  localparam S_RX = 5'b00010;
  localparam S_ACK = 5'b00100;
  localparam S_TX = 5'b01000;
  localparam S_RACK = 5'b10000;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Order: scl, sda, addr select, wp, select, force low, inputs E..A
  reg [10:0] sy1;
  reg [10:0] sy2;
  reg [10:0] sy3;
  reg [10:0] filt;
  reg scl_prev;
  reg sda_prev;
  wire [10:0] pins_raw;

  assign pins_raw = {scl, sda_in, addr_select_pin, wp, mux_select_pin, force_low_n,
                     external_sel_in};

  // A level counts only when the second and third stages agree.
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sy1 <= 11'h7FF;
      sy2 <= 11'h7FF;
      sy3 <= 11'h7FF;
      filt <= 11'h7FF;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      sy1 <= pins_raw;
      sy2 <= sy1;
      sy3 <= sy2;
      filt <= ((sy2 ~^ sy3) & sy3) | ((sy2 ^ sy3) & filt);
      scl_prev <= filt[10];
      sda_prev <= filt[9];
    end
  end

  wire scl_f = filt[10];
  wire sda_f = filt[9];
  wire addr_pin_f = filt[8];
  wire wp_f = filt[7];
  wire sel_f = filt[6];
  wire force_n_f = filt[5];
  wire [4:0] ext_f = filt[4:0];

  wire scl_rise = scl_f & ~scl_prev;
  wire scl_fall = ~scl_f & scl_prev;
  wire start_cond = scl_f & scl_prev & sda_prev & ~sda_f;
  wire stop_cond = scl_f & scl_prev & ~sda_prev & sda_f;

  // ****************************************************************
  // Non-volatile store
  // ****************************************************************
  reg prog_start;
  reg [5:0] prog_data;
  wire [5:0] stored;
  wire store_busy;

  nvmux_store #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_store (
    .mclk(mclk),
    .resetn(resetn),
    .prog_start(prog_start),
    .prog_data(prog_data),
    .stored(stored),
    .busy(store_busy)
  );

  // ****************************************************************
  // Serial target
  // ****************************************************************
  reg [4:0] state;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg [7:0] txbyte;
  reg [1:0] byte_idx;
  reg [7:0] cmd;
  reg rw;
  reg ack_ok;
  reg armed;
  reg [1:0] ctrl;
  reg [4:0] in_latch;
  reg fixed_hold;
  wire [7:0] rx_byte = {shreg[6:0], sda_f};

  // Read answer for the last command; bits above each field read as zero
  function [7:0] read_byte;
    input [7:0] c;
    input [5:0] st;
    input [1:0] cr;
    input [4:0] il;
    begin
      if (c == `NVMUX_CMD_STORE) begin
        read_byte = {2'b00, st};
      end else if (c == `NVMUX_CMD_INPUTS) begin
        read_byte = {3'b000, il};
      end else if (c == `NVMUX_CMD_CTRL) begin
        read_byte = {6'h00, cr};
      end else begin
        read_byte = 8'h00;
      end
    end
  endfunction

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txbyte <= 8'h00;
      byte_idx <= 2'h0;
      cmd <= 8'h00;
      rw <= 1'b0;
      ack_ok <= 1'b0;
      armed <= 1'b0;
      ctrl <= `NVMUX_CTRL_RESET;
      in_latch <= 5'h00;
      prog_start <= 1'b0;
      prog_data <= 6'h00;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      fixed_hold <= 1'b0;
    end else begin
      prog_start <= 1'b0;
      // Pin mode latch: transparent while select is low, frozen on its rise
      if (!ctrl[`NVMUX_CTRL_ENABLE_BIT] && !sel_f) begin
        fixed_hold <= stored[5];
      end
      if (start_cond) begin
        state <= S_RX;
        bitcnt <= 4'h0;
        byte_idx <= 2'h0;
        sda_oe <= 1'b0;
      end else if (stop_cond) begin
        // Programming begins only at STOP after a complete write
        if (armed && !wp_f && !store_busy) begin
          prog_start <= 1'b1;
        end
        armed <= 1'b0;
        state <= S_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            sda_oe <= 1'b0;
          end
          S_RX: begin
            if (scl_rise && bitcnt < 4'h8) begin
              shreg <= rx_byte;
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              state <= S_ACK;
              ack_ok <= 1'b0;
              sda_oe <= 1'b0;
              case (byte_idx)
                2'h0: begin
                  // Busy store refuses every access until its cycle ends
                  if (shreg[7:1] == {`NVMUX_ADDR_FIXED, addr_pin_f} &&
                      !store_busy) begin
                    ack_ok <= 1'b1;
                    sda_oe <= 1'b1;
                    rw <= shreg[0];
                    txbyte <= read_byte(cmd, stored, ctrl, in_latch);
                  end
                end
                2'h1: begin
                  if (shreg == `NVMUX_CMD_STORE || shreg == `NVMUX_CMD_CTRL ||
                      shreg == `NVMUX_CMD_INPUTS) begin
                    ack_ok <= 1'b1;
                    sda_oe <= 1'b1;
                    cmd <= shreg;
                  end
                  if (shreg == `NVMUX_CMD_INPUTS) begin
                    in_latch <= ext_f;
                  end
                end
                2'h2: begin
                  ack_ok <= 1'b1;
                  sda_oe <= 1'b1;
                  if (cmd == `NVMUX_CMD_CTRL) begin
                    ctrl <= shreg[1:0];
                    // Capture at the acknowledge of a 0 to 1 source change
                    if (shreg[`NVMUX_CTRL_ENABLE_BIT] &&
                        shreg[`NVMUX_CTRL_SOURCE_BIT] &&
                        !ctrl[`NVMUX_CTRL_SOURCE_BIT]) begin
                      fixed_hold <= stored[5];
                    end
                  end
                end
                default: begin
                  // Protected or non-store data is refused with a NACK
                  if (cmd == `NVMUX_CMD_STORE && !rw && !wp_f) begin
                    ack_ok <= 1'b1;
                    sda_oe <= 1'b1;
                    armed <= 1'b1;
                    prog_data <= shreg[5:0];
                  end
                end
              endcase
              if (byte_idx != 2'h3) begin
                byte_idx <= byte_idx + 2'h1;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              if (!ack_ok) begin
                state <= S_IDLE;
                sda_oe <= 1'b0;
              end else if (rw && byte_idx == 2'h1) begin
                state <= S_TX;
                bitcnt <= 4'h0;
                shreg <= txbyte;
                sda_oe <= ~txbyte[7];
              end else begin
                state <= S_RX;
                sda_oe <= 1'b0;
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bitcnt == 4'h7) begin
                state <= S_RACK;
                sda_oe <= 1'b0;
              end else begin
                bitcnt <= bitcnt + 4'h1;
                shreg <= {shreg[6:0], 1'b0};
                sda_oe <= ~shreg[6];
              end
            end
          end
          S_RACK: begin
            if (scl_rise) begin
              ack_ok <= ~sda_f;
            end else if (scl_fall) begin
              if (ack_ok) begin
                state <= S_TX;
                bitcnt <= 4'h0;
                shreg <= txbyte;
                sda_oe <= ~txbyte[7];
              end else begin
                state <= S_IDLE;
              end
            end
          end
          default: begin
            state <= S_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Output selection
  // ****************************************************************
  reg src_store;
  reg [4:0] next_selected;
  reg next_fixed;

  always @* begin
    if (ctrl[`NVMUX_CTRL_ENABLE_BIT]) begin
      src_store = ctrl[`NVMUX_CTRL_SOURCE_BIT];
    end else begin
      src_store = ~sel_f;
    end
    if (src_store) begin
      // Override only acts on the stored source
      next_selected = force_n_f ? stored[4:0] : 5'h00;
      next_fixed = force_n_f ? stored[5] : 1'b0;
    end else begin
      next_selected = ext_f;
      next_fixed = fixed_hold;
    end
  end

  // Open-drain pins: enable high pulls the pin low
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      selected_out <= 5'h00;
      selected_out_oe <= 5'h1F;
      fixed_out <= 1'b0;
      fixed_out_oe <= 1'b1;
      prog_busy <= 1'b0;
    end else begin
      selected_out <= next_selected;
      selected_out_oe <= ~next_selected;
      fixed_out <= next_fixed;
      fixed_out_oe <= ~next_fixed;
      prog_busy <= store_busy;
    end
  end

endmodule

// ---- shared/nvmux_map.vh ----
// Constants for the stored-value output selector with its serial target port
`ifndef NVMUX_MAP_VH
`define NVMUX_MAP_VH

// ****************************************************************
// Target address and command codes
// ****************************************************************
`define NVMUX_ADDR_FIXED 6'h2A
`define NVMUX_CMD_STORE 8'h01
`define NVMUX_CMD_CTRL 8'h02
`define NVMUX_CMD_INPUTS 8'h03

// ****************************************************************
// Control register fields and reset values
// ****************************************************************
`define NVMUX_CTRL_ENABLE_BIT 0
`define NVMUX_CTRL_SOURCE_BIT 1
`define NVMUX_CTRL_RESET 2'h0
`define NVMUX_STORE_RESET 6'h00

// ****************************************************************
// Timing
// ****************************************************************
`define NVMUX_CLK_MHZ 250
`define NVMUX_T_PROG_US 4000
`define NVMUX_PROG_CYCLES (`NVMUX_T_PROG_US * `NVMUX_CLK_MHZ)

`endif
